// >>> hdl/ebpm_pkg.sv
// Constants and types for the external bus port pin multiplexer
package ebpm_pkg;

  localparam int ADP_W = 16;
  localparam int ADDR_W = 16;
  localparam int CSP_W = 8;
  localparam int BCP_W = 15;
  localparam int SCP_W = 6;
  localparam int AIP_W = 12;
  localparam int NUM_CS = 5;
  localparam int CSP_HOLD_REQ = 5;
  localparam int CSP_HOLD_ACK = 6;
  localparam int CSP_BUS_REQ = 7;
  localparam int BCP_HIGH_BYTE = 12;
  localparam int AIP_T6_IN = 8;
  localparam int AIP_T5_IN = 9;
  localparam int AIP_T4_DIR = 10;
  localparam int AIP_T2_DIR = 11;

  // Bus configuration
  typedef enum logic [2:0] {
    EBPM_BUS_OFF = 3'b000,
    EBPM_BUS_DEMUX8 = 3'b001,
    EBPM_BUS_DEMUX16 = 3'b010,
    EBPM_BUS_MUX8 = 3'b011,
    EBPM_BUS_MUX16 = 3'b100
  } ebpm_bus_mode_t;

  // Bus-side request from the external bus controller
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [ADP_W-1:0] wdata;
    logic addr_phase;
    logic data_out;
    logic [NUM_CS-1:0] cs_n;
    logic high_byte_n;
    logic high_byte_wr_n;
    logic use_write_strobe;
  } ebpm_bus_req_t;

  // Per-port general-purpose settings
  typedef struct packed {
    logic [ADP_W-1:0] dir_out;
    logic [ADP_W-1:0] open_drain;
    logic [ADP_W-1:0] out_val;
    logic special_thr;
  } ebpm_gp_cfg_t;

  // Drive of one pin group
  typedef struct packed {
    logic [ADP_W-1:0] out;
    logic [ADP_W-1:0] oe;
  } ebpm_pin_drv_t;

endpackage : ebpm_pkg

// >>> hdl/ebpm_pin_mux.sv
// Pin multiplexer for ports and external bus roles
`timescale 1ns/1ps
`default_nettype none
module ebpm_pin_mux (
  input wire logic clock, // System clock
  input wire logic rstn, // Async reset, active low
  input wire ebpm_pkg::ebpm_bus_mode_t bus_mode, // Selected bus configuration
  input wire ebpm_pkg::ebpm_bus_req_t bus_req, // Bus controller drive
  input wire logic bus_master, // Device owns the bus
  input wire logic bus_need, // Device wants the bus
  input wire logic hold_acknowledge_drive, // Hold acknowledge level as master
  input wire logic [ebpm_pkg::NUM_CS-1:0] cs_enable, // Chip select pins claimed
  input wire ebpm_pkg::ebpm_gp_cfg_t gp_adp_cfg, // Address/data port GP setup
  input wire ebpm_pkg::ebpm_gp_cfg_t gp_adr_cfg, // Address port GP setup
  input wire ebpm_pkg::ebpm_gp_cfg_t gp_csp_cfg, // Chip-select port GP setup
  input wire ebpm_pkg::ebpm_gp_cfg_t gp_bcp_cfg, // Bus-control port GP setup
  input wire ebpm_pkg::ebpm_gp_cfg_t gp_scp_cfg, // Secondary capture port GP setup
  input wire logic external_access_input, // External access pin
  input wire logic [ebpm_pkg::ADP_W-1:0] addr_data_port_in, // Pin level
  output logic [ebpm_pkg::ADP_W-1:0] addr_data_port_out, // Pin drive value
  output logic [ebpm_pkg::ADP_W-1:0] addr_data_port_oe, // Pin drive enable
  input wire logic [ebpm_pkg::ADDR_W-1:0] address_port_in, // Pin level
  output logic [ebpm_pkg::ADDR_W-1:0] address_port_out, // Pin drive value
  output logic [ebpm_pkg::ADDR_W-1:0] address_port_oe, // Pin drive enable
  input wire logic [ebpm_pkg::CSP_W-1:0] chip_select_port_in, // Pin level
  output logic [ebpm_pkg::CSP_W-1:0] chip_select_port_out, // Pin drive value
  output logic [ebpm_pkg::CSP_W-1:0] chip_select_port_oe, // Pin drive enable
  input wire logic [ebpm_pkg::BCP_W-1:0] bus_control_port_in, // Pin level
  output logic [ebpm_pkg::BCP_W-1:0] bus_control_port_out, // Pin drive value
  output logic [ebpm_pkg::BCP_W-1:0] bus_control_port_oe, // Pin drive enable
  input wire logic [ebpm_pkg::SCP_W-1:0] secondary_capture_port_in, // Pin level
  output logic [ebpm_pkg::SCP_W-1:0] secondary_capture_port_out, // Pin drive value
  output logic [ebpm_pkg::SCP_W-1:0] secondary_capture_port_oe, // Pin drive enable
  input wire logic [ebpm_pkg::AIP_W-1:0] analog_input_port_in, // Input-only pins
  output logic [ebpm_pkg::ADP_W-1:0] adp_rdata, // Synced address/data port level
  output logic [ebpm_pkg::ADDR_W-1:0] adr_rdata, // Synced address port level
  output logic [ebpm_pkg::CSP_W-1:0] csp_rdata, // Synced chip-select port level
  output logic [ebpm_pkg::BCP_W-1:0] bcp_rdata, // Synced bus-control port level
  output logic [ebpm_pkg::SCP_W-1:0] scp_rdata, // Synced secondary port level
  output logic [ebpm_pkg::AIP_W-1:0] aip_rdata, // Synced analog port digital level
  output logic [4:0] special_thr, // Threshold select per port
  output logic hold_request, // Synced hold request
  output logic hold_acknowledge_in, // Synced hold acknowledge (slave)
  output logic [3:0] timer_inputs, // T6 in, T5 in, T4 dir, T2 dir
  output logic [ebpm_pkg::ADP_W-1:0] config_value, // Strap captured at reset end
  output logic config_valid // Strap captured with external access input low
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = ebpm_pkg::ADP_W + ebpm_pkg::ADDR_W + ebpm_pkg::CSP_W + ebpm_pkg::BCP_W
                          + ebpm_pkg::SCP_W + ebpm_pkg::AIP_W + 1;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  wire [SYNC_W-1:0] raw_pins = {external_access_input, analog_input_port_in, secondary_capture_port_in,
                                bus_control_port_in, chip_select_port_in, address_port_in, addr_data_port_in};
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= raw_pins;
      sync_b <= sync_a;
    end
  end
  wire [ebpm_pkg::ADP_W-1:0] s_adp = sync_b[15:0];
  wire [ebpm_pkg::ADDR_W-1:0] s_adr = sync_b[31:16];
  wire [ebpm_pkg::CSP_W-1:0] s_csp = sync_b[39:32];
  wire [ebpm_pkg::BCP_W-1:0] s_bcp = sync_b[54:40];
  wire [ebpm_pkg::SCP_W-1:0] s_scp = sync_b[60:55];
  wire [ebpm_pkg::AIP_W-1:0] s_aip = sync_b[72:61];
  wire s_ea = sync_b[73];

  // ----------------------------------------------------------------
  // General-purpose drive, input is high-Z, open-drain drives low only
  // ----------------------------------------------------------------
  function automatic ebpm_pkg::ebpm_pin_drv_t gp_drive(input ebpm_pkg::ebpm_gp_cfg_t c);
    ebpm_pkg::ebpm_pin_drv_t d;
    d.out = c.out_val;
    d.oe = c.dir_out & ~(c.open_drain & c.out_val);
    return d;
  endfunction : gp_drive

  wire ebpm_pkg::ebpm_pin_drv_t adp_gp = gp_drive(gp_adp_cfg);
  wire ebpm_pkg::ebpm_pin_drv_t adr_gp = gp_drive(gp_adr_cfg);
  wire ebpm_pkg::ebpm_pin_drv_t csp_gp = gp_drive(gp_csp_cfg);
  wire ebpm_pkg::ebpm_pin_drv_t bcp_gp = gp_drive(gp_bcp_cfg);
  wire ebpm_pkg::ebpm_pin_drv_t scp_gp = gp_drive(gp_scp_cfg);

  // ----------------------------------------------------------------
  // Bus role decode
  // ----------------------------------------------------------------
  wire bus_on = bus_master && (bus_mode != ebpm_pkg::EBPM_BUS_OFF);
  wire is_mux = (bus_mode == ebpm_pkg::EBPM_BUS_MUX8) || (bus_mode == ebpm_pkg::EBPM_BUS_MUX16);
  wire wide = (bus_mode == ebpm_pkg::EBPM_BUS_DEMUX16) || (bus_mode == ebpm_pkg::EBPM_BUS_MUX16);
  wire lo_claim = bus_on;
  wire hi_claim = bus_on && (is_mux || wide);
  wire lo_drive = bus_req.addr_phase ? is_mux : bus_req.data_out;
  wire hi_drive = (is_mux && (!wide || bus_req.addr_phase)) || (!bus_req.addr_phase && bus_req.data_out && wide);
  wire [7:0] lo_val = (is_mux && bus_req.addr_phase) ? bus_req.addr[7:0] : bus_req.wdata[7:0];
  wire [7:0] hi_val = (is_mux && (bus_req.addr_phase || !wide)) ? bus_req.addr[15:8] : bus_req.wdata[15:8];

  // Demux address stays on the address port once a demux mode was used, until bus_mode returns to EBPM_BUS_OFF
  logic demux_seen;
  wire next_demux_seen = demux_seen || (bus_on && !is_mux);
  wire adr_claim = bus_on && (!is_mux || demux_seen);

  wire [ebpm_pkg::ADP_W-1:0] adp_claim = {{8{hi_claim}}, {8{lo_claim}}};
  wire [ebpm_pkg::ADP_W-1:0] next_adp_out = (adp_claim & {hi_val, lo_val}) | (~adp_claim & adp_gp.out);
  wire [ebpm_pkg::ADP_W-1:0] next_adp_oe = (adp_claim & {{8{hi_drive}}, {8{lo_drive}}}) | (~adp_claim & adp_gp.oe);
  wire [ebpm_pkg::ADDR_W-1:0] next_adr_out = adr_claim ? bus_req.addr : adr_gp.out;
  wire [ebpm_pkg::ADDR_W-1:0] next_adr_oe = adr_claim ? '1 : adr_gp.oe;

  // Chip-select port alternates
  logic [ebpm_pkg::CSP_W-1:0] next_csp_out;
  logic [ebpm_pkg::CSP_W-1:0] next_csp_oe;
  genvar gi;
  generate
    for (gi = 0; gi < ebpm_pkg::CSP_W; gi++) begin : g_csp
      if (gi < ebpm_pkg::NUM_CS) begin : g_cs
        assign next_csp_out[gi] = (bus_on && cs_enable[gi]) ? bus_req.cs_n[gi] : csp_gp.out[gi];
        assign next_csp_oe[gi] = (bus_on && cs_enable[gi]) ? 1'b1 : csp_gp.oe[gi];
      end else if (gi == ebpm_pkg::CSP_HOLD_ACK) begin : g_hold_acknowledge
        assign next_csp_out[gi] = bus_on ? hold_acknowledge_drive : csp_gp.out[gi];
        assign next_csp_oe[gi] = bus_on ? bus_master : csp_gp.oe[gi];
      end else if (gi == ebpm_pkg::CSP_BUS_REQ) begin : g_bus_request_out
        assign next_csp_out[gi] = bus_on ? bus_need : csp_gp.out[gi];
        assign next_csp_oe[gi] = bus_on ? 1'b1 : csp_gp.oe[gi];
      end else begin : g_gp
        assign next_csp_out[gi] = csp_gp.out[gi];
        assign next_csp_oe[gi] = csp_gp.oe[gi];
      end
    end
  endgenerate

  // High byte enable or write strobe on the bus-control port
  wire hb_val = bus_req.use_write_strobe ? bus_req.high_byte_wr_n : bus_req.high_byte_n;
  wire hb_claim = bus_on && wide;
  wire [ebpm_pkg::BCP_W-1:0] hb_mask = {{(ebpm_pkg::BCP_W-1){1'b0}}, 1'b1} << ebpm_pkg::BCP_HIGH_BYTE;
  wire [ebpm_pkg::BCP_W-1:0] next_bcp_out = hb_claim ? ((bcp_gp.out[14:0] & ~hb_mask) | ({15{hb_val}} & hb_mask))
                                                     : bcp_gp.out[14:0];
  wire [ebpm_pkg::BCP_W-1:0] next_bcp_oe = hb_claim ? (bcp_gp.oe[14:0] | hb_mask) : bcp_gp.oe[14:0];

  // Strap capture on the third edge after reset release
  logic strap_done;
  logic [1:0] strap_wait;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_data_port_out <= '0;
      addr_data_port_oe <= '0;
      address_port_out <= '0;
      address_port_oe <= '0;
      chip_select_port_out <= '0;
      chip_select_port_oe <= '0;
      bus_control_port_out <= '0;
      bus_control_port_oe <= '0;
      secondary_capture_port_out <= '0;
      secondary_capture_port_oe <= '0;
      demux_seen <= 1'b0;
    end else begin
      addr_data_port_out <= next_adp_out;
      addr_data_port_oe <= next_adp_oe;
      address_port_out <= next_adr_out;
      address_port_oe <= next_adr_oe;
      chip_select_port_out <= next_csp_out;
      chip_select_port_oe <= next_csp_oe;
      bus_control_port_out <= next_bcp_out;
      bus_control_port_oe <= next_bcp_oe;
      secondary_capture_port_out <= scp_gp.out[5:0];
      secondary_capture_port_oe <= scp_gp.oe[5:0];
      demux_seen <= bus_mode == ebpm_pkg::EBPM_BUS_OFF ? 1'b0 : next_demux_seen;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      adp_rdata <= '0;
      adr_rdata <= '0;
      csp_rdata <= '0;
      bcp_rdata <= '0;
      scp_rdata <= '0;
      aip_rdata <= '0;
      special_thr <= '0;
      hold_request <= 1'b0;
      hold_acknowledge_in <= 1'b0;
      timer_inputs <= '0;
    end else begin
      adp_rdata <= s_adp;
      adr_rdata <= s_adr;
      csp_rdata <= s_csp;
      bcp_rdata <= s_bcp;
      scp_rdata <= s_scp;
      aip_rdata <= s_aip;
      special_thr <= {gp_scp_cfg.special_thr, gp_bcp_cfg.special_thr, gp_csp_cfg.special_thr,
                      gp_adr_cfg.special_thr, gp_adp_cfg.special_thr};
      hold_request <= s_csp[ebpm_pkg::CSP_HOLD_REQ];
      hold_acknowledge_in <= bus_master ? 1'b0 : s_csp[ebpm_pkg::CSP_HOLD_ACK];
      timer_inputs <= {s_aip[ebpm_pkg::AIP_T6_IN], s_aip[ebpm_pkg::AIP_T5_IN],
                       s_aip[ebpm_pkg::AIP_T4_DIR], s_aip[ebpm_pkg::AIP_T2_DIR]};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_wait <= '0;
      strap_done <= 1'b0;
      config_value <= '0;
      config_valid <= 1'b0;
    end else begin
      if (strap_wait != 2'h2) begin
        strap_wait <= strap_wait + 2'h1;
      end else if (!strap_done) begin
        strap_done <= 1'b1;
        config_value <= s_adp;
        config_valid <= !s_ea;
      end
    end
  end

endmodule : ebpm_pin_mux
`default_nettype wire

// >>> test/ebpm_pin_mux_chk.sv
// Concurrent checks on pin ownership and strap capture
`timescale 1ns/1ps
`default_nettype none
module ebpm_pin_mux_chk (
  input wire logic clock, // Clock
  input wire logic rstn, // Reset
  input wire ebpm_pkg::ebpm_bus_mode_t bus_mode, // Mode
  input wire ebpm_pkg::ebpm_bus_req_t bus_req, // Bus drive
  input wire logic bus_master, // Owner
  input wire logic [4:0] cs_enable, // Claims
  input wire ebpm_pkg::ebpm_gp_cfg_t gp_scp_cfg, // Setup
  input wire logic [15:0] addr_data_port_out, // Drive
  input wire logic [15:0] addr_data_port_oe, // Enable
  input wire logic [15:0] address_port_out, // Drive
  input wire logic [15:0] address_port_oe, // Enable
  input wire logic [7:0] chip_select_port_out, // Drive
  input wire logic [7:0] chip_select_port_oe, // Enable
  input wire logic [5:0] secondary_capture_port_out, // Drive
  input wire logic [5:0] secondary_capture_port_oe, // Enable
  input wire logic hold_acknowledge_in, // Slave ack
  input wire logic [15:0] config_value, // Strap
  input wire logic config_valid // Strap taken with external access low
);
  // ---------------------------------------------
  // Ownership checks
  // ---------------------------------------------
  logic live;
  wire logic on = bus_master && bus_mode != ebpm_pkg::EBPM_BUS_OFF;
  wire logic dm = bus_mode == ebpm_pkg::EBPM_BUS_DEMUX8 || bus_mode == ebpm_pkg::EBPM_BUS_DEMUX16;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // One active edge since reset before outputs follow inputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) live <= 1'b0;
    else live <= 1'b1;
  end
  a_gp_pin_oe: assert property (live |-> secondary_capture_port_oe ==
    $past(gp_scp_cfg.dir_out[5:0] & ~(gp_scp_cfg.open_drain[5:0] & gp_scp_cfg.out_val[5:0])))
    else $error("port enable wrong");
  a_gp_pin_out: assert property (live |-> secondary_capture_port_out == $past(gp_scp_cfg.out_val[5:0]))
    else $error("port value wrong");
  a_demux_addr: assert property (live && $past(on && dm) |->
    address_port_oe == 16'hffff && address_port_out == $past(bus_req.addr)) else $error("address port wrong");
  a_mux16_share: assert property (live && $past(on && bus_mode == ebpm_pkg::EBPM_BUS_MUX16 && bus_req.addr_phase)
    |-> addr_data_port_oe == 16'hffff && addr_data_port_out == $past(bus_req.addr)) else $error("mux16 wrong");
  a_mux8_high: assert property (live && $past(on && bus_mode == ebpm_pkg::EBPM_BUS_MUX8) |->
    addr_data_port_oe[15:8] == 8'hff && addr_data_port_out[15:8] == $past(bus_req.addr[15:8]))
    else $error("mux8 high byte wrong");
  a_demux16_data: assert property (live && $past(on && bus_mode == ebpm_pkg::EBPM_BUS_DEMUX16 &&
    bus_req.data_out && !bus_req.addr_phase) |-> addr_data_port_oe == 16'hffff &&
    addr_data_port_out == $past(bus_req.wdata)) else $error("demux16 data wrong");
  a_cs_claim: assert property (live && $past(on && cs_enable[0]) |-> chip_select_port_oe[0] &&
    chip_select_port_out[0] == $past(bus_req.cs_n[0])) else $error("chip select wrong");
  a_master_ack: assert property (live && $past(bus_master) |-> !hold_acknowledge_in)
    else $error("hold ack input while master");
  a_strap_keep: assert property (config_valid && $past(config_valid) |-> $stable(config_value))
    else $error("strap value moved");
  c_mux16: cover property (on && bus_mode == ebpm_pkg::EBPM_BUS_MUX16);
  c_demux8: cover property (on && bus_mode == ebpm_pkg::EBPM_BUS_DEMUX8);
  c_strap: cover property (config_valid);
endmodule : ebpm_pin_mux_chk
`default_nettype wire

// >>> test/ebpm_far_side.sv
// Far-side model: memories, other master and strap drivers
`timescale 1ns/1ps
`default_nettype none
module ebpm_far_side #(
  parameter int W = 16
) (
  input wire logic clock, // Clock
  input wire logic [W-1:0] out, // Device value
  input wire logic [W-1:0] oe, // Device enable
  input wire logic [W-1:0] ext_val, // Far-side value
  input wire logic ext_en, // Far side drives
  output logic [W-1:0] pin // Wire level
);
  // ---------------------------------------------
  // Wire resolution
  // ---------------------------------------------
  logic [W-1:0] flt = '0;
  // Strap, hold request and slave hold ack levels
  assign pin = (oe & out) | (~oe & (ext_en ? ext_val : flt));
  // Released lines show the inverse of the last driven level
  wire [W-1:0] drv = oe | {W{ext_en}};
  always @(posedge clock) flt <= (drv & ~pin) | (~drv & flt);
endmodule : ebpm_far_side
`default_nettype wire

// >>> test/test_external_bus_port_pin_mux.sv
// Self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_port_pin_mux;
  // ---------------------------------------------
  // Stimulus, model and comparison
  // ---------------------------------------------
  logic clock = 1'b0, rstn = 1'b0, mst = 1'b0, need = 1'b0, hack = 1'b0, ea = 1'b1, xe = 1'b1, seen = 1'b0;
  ebpm_pkg::ebpm_bus_mode_t mode = ebpm_pkg::EBPM_BUS_OFF;
  ebpm_pkg::ebpm_bus_req_t rq = '0;
  ebpm_pkg::ebpm_gp_cfg_t c0 = '0, c1 = '0, c2 = '0, c3 = '0, c4 = '0;
  logic [4:0] cse = '0, thr;
  logic [15:0] xv = '0, av = '0, adp_pin, adr_pin, adp_o, adp_e, adr_o, adr_e, adp_rd, adr_rd, cfgv;
  logic [7:0] cv = '0, csp_pin, csp_o, csp_e, csp_rd;
  logic [14:0] bv = '0, bcp_pin, bcp_o, bcp_e, bcp_rd;
  logic [5:0] sv = '0, scp_pin, scp_o, scp_e, scp_rd;
  logic [11:0] aip = '0, aip_rd;
  logic [3:0] tmr;
  logic hreq, hain, cfgok;
  int err_count = 0, checked = 0;
  logic [31:0] seed = 32'h86c30d87;
  ebpm_pkg::ebpm_bus_mode_t md [9] = '{ebpm_pkg::EBPM_BUS_OFF, ebpm_pkg::EBPM_BUS_DEMUX8,
    ebpm_pkg::EBPM_BUS_DEMUX16, ebpm_pkg::EBPM_BUS_MUX8, ebpm_pkg::EBPM_BUS_MUX16, ebpm_pkg::EBPM_BUS_OFF,
    ebpm_pkg::EBPM_BUS_MUX8, ebpm_pkg::EBPM_BUS_MUX16, ebpm_pkg::EBPM_BUS_DEMUX16};
  logic [8:0] mm = 9'h17f;
  always #50 clock = ~clock;
  ebpm_far_side #(.W(16)) u_far_adp (.clock(clock), .out(adp_o), .oe(adp_e), .ext_val(xv), .ext_en(xe), .pin(adp_pin));
  ebpm_far_side #(.W(16)) u_far_adr (.clock(clock), .out(adr_o), .oe(adr_e), .ext_val(av), .ext_en(xe), .pin(adr_pin));
  ebpm_far_side #(.W(8)) u_far_csp (.clock(clock), .out(csp_o), .oe(csp_e), .ext_val(cv), .ext_en(xe), .pin(csp_pin));
  ebpm_far_side #(.W(15)) u_far_bcp (.clock(clock), .out(bcp_o), .oe(bcp_e), .ext_val(bv), .ext_en(xe), .pin(bcp_pin));
  ebpm_far_side #(.W(6)) u_far_scp (.clock(clock), .out(scp_o), .oe(scp_e), .ext_val(sv), .ext_en(xe), .pin(scp_pin));
  ebpm_pin_mux u_ebpm_pin_mux (.clock(clock), .rstn(rstn), .bus_mode(mode), .bus_req(rq), .bus_master(mst),
    .bus_need(need), .hold_acknowledge_drive(hack), .cs_enable(cse), .gp_adp_cfg(c0), .gp_adr_cfg(c1),
    .gp_csp_cfg(c2), .gp_bcp_cfg(c3), .gp_scp_cfg(c4), .external_access_input(ea), .addr_data_port_in(adp_pin),
    .addr_data_port_out(adp_o), .addr_data_port_oe(adp_e), .address_port_in(adr_pin), .address_port_out(adr_o),
    .address_port_oe(adr_e), .chip_select_port_in(csp_pin), .chip_select_port_out(csp_o),
    .chip_select_port_oe(csp_e), .bus_control_port_in(bcp_pin), .bus_control_port_out(bcp_o),
    .bus_control_port_oe(bcp_e), .secondary_capture_port_in(scp_pin), .secondary_capture_port_out(scp_o),
    .secondary_capture_port_oe(scp_e), .analog_input_port_in(aip), .adp_rdata(adp_rd), .adr_rdata(adr_rd),
    .csp_rdata(csp_rd), .bcp_rdata(bcp_rd), .scp_rdata(scp_rd), .aip_rdata(aip_rd), .special_thr(thr),
    .hold_request(hreq), .hold_acknowledge_in(hain), .timer_inputs(tmr), .config_value(cfgv),
    .config_valid(cfgok));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] gpe(input ebpm_pkg::ebpm_gp_cfg_t c);
    return c.dir_out & ~(c.open_drain & c.out_val);
  endfunction : gpe
  task automatic cmp(input string nm, input logic [63:0] e, g, m);
    checked++;
    if ((g & m) !== (e & m)) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e & m, g);
    end
  endtask : cmp
  task automatic port_cmp(input string nm, input logic [15:0] eo, ee, mo, go, ge);
    cmp({nm, " oe"}, {48'h0, ee}, {48'h0, ge}, {48'h0, mo});
    cmp({nm, " out"}, {48'h0, eo}, {48'h0, go}, {48'h0, mo & ee});
  endtask : port_cmp
  task automatic step(input ebpm_pkg::ebpm_bus_mode_t m, input logic ms);
    logic [63:0] r [7];
    logic [15:0] eo, ee, mo, db, dv;
    logic [7:0] sel;
    logic on, dm, de;
    for (int i = 0; i < 7; i++) r[i] = {rnd(), rnd()};
    @(posedge clock);
    mode <= m;
    {mst, rq, c0, c1} <= {ms, r[0][41:0], r[1][48:0], r[2][48:0]};
    {c2, c3, c4, xe, need, hack, cse, xv, cv} <= {r[3][48:0], r[4][48:0], r[5][48:0], r[6][31:0]};
    @(posedge clock);
    @(negedge clock);
    on = mst && mode != ebpm_pkg::EBPM_BUS_OFF;
    dm = mode == ebpm_pkg::EBPM_BUS_DEMUX8 || mode == ebpm_pkg::EBPM_BUS_DEMUX16;
    seen = (seen || (on && dm)) && mode != ebpm_pkg::EBPM_BUS_OFF;
    db = !on ? 16'h0000 : (mode == ebpm_pkg::EBPM_BUS_DEMUX8 ? 16'h00ff : 16'hffff);
    dv = (dm || !rq.addr_phase) ? rq.wdata : rq.addr;
    de = dm ? (rq.data_out && !rq.addr_phase) : (rq.addr_phase || rq.data_out);
    eo = (c0.out_val & ~db) | (dv & db);
    ee = (gpe(c0) & ~db) | ({16{de}} & db);
    mo = 16'hffff;
    if (on && mode == ebpm_pkg::EBPM_BUS_MUX8) {eo[15:8], ee[15:8]} = {rq.addr[15:8], 8'hff};
    port_cmp("adp", eo, ee, mo, adp_o, adp_e);
    {eo, ee, mo} = (on && (dm || seen)) ? {rq.addr, 32'hffffffff} : {c1.out_val, gpe(c1), 16'hffff};
    port_cmp("adr", eo, ee, mo, adr_o, adr_e);
    sel = on ? {3'b110, cse} : 8'h00;
    eo = c2.out_val & ~{8'h00, sel} | {8'h00, {need, hack, 1'b0, rq.cs_n} & sel};
    port_cmp("csp", eo, gpe(c2) | {8'h00, sel}, 16'h00df, {8'h00, csp_o}, {8'h00, csp_e});
    {eo, ee} = {c3.out_val, gpe(c3)};
    if (on && (mode == ebpm_pkg::EBPM_BUS_DEMUX16 || mode == ebpm_pkg::EBPM_BUS_MUX16))
      {eo[12], ee[12]} = {rq.use_write_strobe ? rq.high_byte_wr_n : rq.high_byte_n, 1'b1};
    port_cmp("bcp", eo, ee, 16'h7fff, {1'b0, bcp_o}, {1'b0, bcp_e});
    cmp("thr", {59'h0, c4.special_thr, c3.special_thr, c2.special_thr, c1.special_thr, c0.special_thr},
      {59'h0, thr}, '1);
  endtask : step
  task automatic idle();
    logic [95:0] r;
    r = {rnd(), rnd(), rnd()};
    @(posedge clock);
    mode <= ebpm_pkg::EBPM_BUS_OFF;
    {mst, c0, c1, c2, c3, c4, xe} <= {1'b0, 245'h0, 1'b1};
    {xv, av, cv, sv, aip, bv} <= r[72:0];
    repeat (5) @(posedge clock);
    @(negedge clock);
    cmp("rd pins", {xv, av, cv, 2'b00, sv, 4'h0, aip}, {adp_rd, adr_rd, csp_rd, 2'b00, scp_rd, 4'h0, aip_rd}, '1);
    cmp("rd ctl", {43'h0, bv, aip[8], aip[9], aip[10], aip[11], cv[5], cv[6]},
      {43'h0, bcp_rd, tmr, hreq, hain}, '1);
  endtask : idle
  task automatic rst(input logic e);
    logic [31:0] r;
    r = rnd();
    @(posedge clock);
    {ea, xv, rstn} <= {e, r[15:0], 1'b0};
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    cmp("strap", {47'h0, !e, e ? 16'h0 : xv}, {47'h0, cfgok, e ? 16'h0 : cfgv}, '1);
  endtask : rst
  task automatic complete_run();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    complete_run();
  end
  initial begin
    rst(1'b1);
    for (int k = 0; k < 9; k++) repeat (12) step(md[k], mm[k]);
    repeat (3) idle();
    rst(1'b0);
    complete_run();
  end
endmodule : test_external_bus_port_pin_mux
bind ebpm_pin_mux ebpm_pin_mux_chk u_chk (.clock, .rstn, .bus_mode, .bus_req, .bus_master, .cs_enable,
  .gp_scp_cfg, .addr_data_port_out, .addr_data_port_oe, .address_port_out, .address_port_oe,
  .chip_select_port_out, .chip_select_port_oe, .secondary_capture_port_out, .secondary_capture_port_oe,
  .hold_acknowledge_in, .config_value, .config_valid);
`default_nettype wire
